// >>> hw/sfs_sampler.sv
// module: per-port statistical frame sampler with register port
// Contract
// - independent sampler, rate, direction, counters per port
// - sampled copy goes to selected CPU queue
// - rate is probability in 1/32768 steps
// - each candidate gets one independent random draw
// - direction bit 0 makes received frames candidates
// - direction bit 1 makes transmitted frames candidates
// - rx and tx share one rate, separately enabled
// - copy marked, check sequence replaced by stamp
// - stamp: id from 26, fwd from 8, samples 0
// - sample counter increments per sent copy
// - candidate counter increments per qualifying frame
// - sticky flags: candidate, source copy, destination copy
// - masked sticky events counted in port statistics
// - per-port count register readable by software
// - global setting puts port number in stamp
//
// Decided for this implementation: the register offsets and strobed register access.
module sfs_sampler (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic clk_en,
	// register port
	input wire logic [sfs_pkg::ADDR_W-1:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	output logic irq,
	// candidate frames from the pipeline
	input wire logic cand_valid,
	input wire logic [sfs_pkg::PORT_W-1:0] cand_port,
	input wire logic cand_dir,
	// sampled copy towards the cpu queue
	output logic copy_valid,
	output logic [sfs_pkg::QUEUE_W-1:0] copy_queue,
	output logic [sfs_pkg::PORT_W-1:0] copy_port,
	output logic copy_dir,
	output logic sampled_copy_marker,
	output logic [31:0] copy_stamp,
	// per-event count pulses to the port statistics block
	output logic [2:0] stat_count_pulse,
	output logic [sfs_pkg::PORT_W-1:0] stat_count_port
);

	// port index from a register address
	function automatic logic [sfs_pkg::PORT_W-1:0] addr_port(input logic [sfs_pkg::ADDR_W-1:0] a);
		addr_port = a[3+sfs_pkg::PORT_W-1:3];
	endfunction

	// true when address lands in the per-port region
	function automatic logic addr_in_ports(input logic [sfs_pkg::ADDR_W-1:0] a);
		addr_in_ports = (a[7:6] == sfs_pkg::PORT_REGION);
	endfunction

	// width of the identifier field in the stamp
	localparam int ID_W = sfs_pkg::ID_W;
	// global settings
	logic sampling_global_enable_q;
	logic stamp_id_include_enable_q;
	logic [sfs_pkg::QUEUE_W-1:0] sample_cpu_queue_select_q;
	// sticky flags and their masks
	logic [2:0] debug_event_flags_q;
	logic [2:0] stat_mask_q;
	logic [2:0] irq_mask_q;
	// per-port configuration and counters
	logic [sfs_pkg::RATE_W-1:0] sampling_probability_q [sfs_pkg::NUM_PORTS];
	logic [1:0] candidate_direction_select_q [sfs_pkg::NUM_PORTS];
	logic [sfs_pkg::SMPL_W-1:0] samples_sent_count_q [sfs_pkg::NUM_PORTS];
	logic [sfs_pkg::FWD_W-1:0] candidate_forward_count_q [sfs_pkg::NUM_PORTS];
	// random source
	logic [31:0] lfsr_q;
	// decode of the current candidate
	logic is_cand;
	logic is_hit;
	logic [sfs_pkg::SMPL_W-1:0] smpl_next;
	logic [sfs_pkg::FWD_W-1:0] fwd_next;
	logic [2:0] ev_now;
	logic wr_glb, wr_sticky, wr_smask, wr_imask, wr_ctrl;

	// register write decode
	always_comb begin
		wr_glb = clk_en && reg_wr && (reg_addr == sfs_pkg::OFF_GLOBAL);
		wr_sticky = clk_en && reg_wr && (reg_addr == sfs_pkg::OFF_STICKY);
		wr_smask = clk_en && reg_wr && (reg_addr == sfs_pkg::OFF_STAT_MASK);
		wr_imask = clk_en && reg_wr && (reg_addr == sfs_pkg::OFF_IRQ_MASK);
		wr_ctrl = clk_en && reg_wr && addr_in_ports(reg_addr) && !reg_addr[2] && (reg_addr[1:0] == 2'h0);
	end

	// candidate qualification and random draw
	always_comb begin
		is_cand = clk_en && cand_valid && sampling_global_enable_q
			&& candidate_direction_select_q[cand_port][cand_dir];
		is_hit = is_cand && (lfsr_q[sfs_pkg::RATE_W-1:0] < sampling_probability_q[cand_port]);
		smpl_next = samples_sent_count_q[cand_port] + 1'b1;
		fwd_next = candidate_forward_count_q[cand_port] + 1'b1;
		ev_now = 3'h0;
		ev_now[sfs_pkg::EV_CAND] = is_cand;
		ev_now[sfs_pkg::EV_SRC] = is_hit && (cand_dir == sfs_pkg::SFS_DIR_RX);
		ev_now[sfs_pkg::EV_DST] = is_hit && (cand_dir == sfs_pkg::SFS_DIR_TX);
	end

	// free-running lfsr, one new value every enabled cycle
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			lfsr_q <= sfs_pkg::LFSR_SEED;
		end else if (clk_en) begin
			lfsr_q <= lfsr_q[0] ? ((lfsr_q >> 1) ^ sfs_pkg::LFSR_TAPS) : (lfsr_q >> 1);
		end
	end

	// global configuration register
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			sampling_global_enable_q <= 1'b0;
			stamp_id_include_enable_q <= 1'b0;
			sample_cpu_queue_select_q <= '0;
		end else if (wr_glb) begin
			sampling_global_enable_q <= reg_wdata[sfs_pkg::GBL_ENA_BIT];
			stamp_id_include_enable_q <= reg_wdata[sfs_pkg::GBL_ID_BIT];
			sample_cpu_queue_select_q <= reg_wdata[sfs_pkg::GBL_QU_LSB +: sfs_pkg::QUEUE_W];
		end
	end

	// masks for statistics and interrupt
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			stat_mask_q <= '0;
			irq_mask_q <= '0;
		end else begin
			if (wr_smask) begin
				stat_mask_q <= reg_wdata[2:0];
			end
			if (wr_imask) begin
				irq_mask_q <= reg_wdata[2:0];
			end
		end
	end

	// sticky debug flags, a new event beats a clear
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			debug_event_flags_q <= '0;
		end else if (clk_en) begin
			debug_event_flags_q <= (debug_event_flags_q & ~(wr_sticky ? reg_wdata[2:0] : 3'h0)) | ev_now;
		end
	end

	// per-port control registers
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			for (int p = 0; p < sfs_pkg::NUM_PORTS; p++) begin
				sampling_probability_q[p] <= '0;
				candidate_direction_select_q[p] <= '0;
			end
		end else if (wr_ctrl) begin
			sampling_probability_q[addr_port(reg_addr)] <= reg_wdata[sfs_pkg::CTRL_RATE_LSB +: sfs_pkg::RATE_W];
			candidate_direction_select_q[addr_port(reg_addr)] <= reg_wdata[sfs_pkg::CTRL_DIR_LSB +: 2];
		end
	end

	// per-port counters
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			for (int p = 0; p < sfs_pkg::NUM_PORTS; p++) begin
				samples_sent_count_q[p] <= '0;
				candidate_forward_count_q[p] <= '0;
			end
		end else begin
			if (is_cand) begin
				candidate_forward_count_q[cand_port] <= fwd_next;
			end
			if (is_hit) begin
				samples_sent_count_q[cand_port] <= smpl_next;
			end
		end
	end

	// sampled copy output, one cycle after the candidate
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			copy_valid <= 1'b0;
			copy_queue <= '0;
			copy_port <= '0;
			copy_dir <= 1'b0;
			sampled_copy_marker <= 1'b0;
			copy_stamp <= sfs_pkg::RST_WORD;
		end else if (clk_en) begin
			copy_valid <= is_hit;
			sampled_copy_marker <= is_hit;
			if (is_hit) begin
				copy_queue <= sample_cpu_queue_select_q;
				copy_port <= cand_port;
				copy_dir <= cand_dir;
				if (stamp_id_include_enable_q) begin
					copy_stamp <= {ID_W'(cand_port), fwd_next[sfs_pkg::STAMP_ID_LSB-sfs_pkg::STAMP_FWD_LSB-1:0],
						smpl_next};
				end else begin
					copy_stamp <= {fwd_next, smpl_next};
				end
			end
		end
	end

	// masked events to the statistics block
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			stat_count_pulse <= '0;
			stat_count_port <= '0;
		end else if (clk_en) begin
			stat_count_pulse <= ev_now & stat_mask_q;
			stat_count_port <= cand_port;
		end
	end

	// register read, data one cycle after the strobe
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			reg_rdata <= sfs_pkg::RST_WORD;
		end else if (clk_en) begin
			reg_rdata <= sfs_pkg::RST_WORD;
			if (reg_rd) begin
				if (reg_addr == sfs_pkg::OFF_GLOBAL) begin
					reg_rdata[sfs_pkg::GBL_ENA_BIT] <= sampling_global_enable_q;
					reg_rdata[sfs_pkg::GBL_ID_BIT] <= stamp_id_include_enable_q;
					reg_rdata[sfs_pkg::GBL_QU_LSB +: sfs_pkg::QUEUE_W] <= sample_cpu_queue_select_q;
				end else if (reg_addr == sfs_pkg::OFF_STICKY) begin
					reg_rdata[2:0] <= debug_event_flags_q;
				end else if (reg_addr == sfs_pkg::OFF_STAT_MASK) begin
					reg_rdata[2:0] <= stat_mask_q;
				end else if (reg_addr == sfs_pkg::OFF_IRQ_MASK) begin
					reg_rdata[2:0] <= irq_mask_q;
				end else if (addr_in_ports(reg_addr) && (reg_addr[1:0] == 2'h0)) begin
					if (reg_addr[2]) begin
						reg_rdata <= {candidate_forward_count_q[addr_port(reg_addr)],
							samples_sent_count_q[addr_port(reg_addr)]};
					end else begin
						reg_rdata[sfs_pkg::CTRL_RATE_LSB +: sfs_pkg::RATE_W] <=
							sampling_probability_q[addr_port(reg_addr)];
						reg_rdata[sfs_pkg::CTRL_DIR_LSB +: 2] <= candidate_direction_select_q[addr_port(reg_addr)];
					end
				end
			end
		end
	end

	// level interrupt from unmasked sticky flags
	always_comb begin
		irq = |(debug_event_flags_q & irq_mask_q);
	end

	// candidate presented and its copy one cycle later
	sequence s_hit;
		clk_en && is_hit;
	endsequence
	sequence s_copy_out;
		copy_valid && sampled_copy_marker;
	endsequence

	property p_port_isolation;
		@(posedge ref_clk) disable iff (rst)
		(is_cand && cand_port != 3'h0) |=> $stable(candidate_forward_count_q[0]);
	endproperty
	a_port_isolation: assert property (p_port_isolation) else $error("other port counter moved");

	property p_queue;
		@(posedge ref_clk) disable iff (rst)
		s_hit ##1 s_copy_out |-> copy_queue == $past(sample_cpu_queue_select_q);
	endproperty
	a_queue: assert property (p_queue) else $error("copy sent to wrong queue");

	property p_rate_zero;
		@(posedge ref_clk) disable iff (rst)
		(cand_valid && sampling_probability_q[cand_port] == 15'h0000) |-> !is_hit;
	endproperty
	a_rate_zero: assert property (p_rate_zero) else $error("sample taken at zero rate");

	property p_direction;
		@(posedge ref_clk) disable iff (rst)
		(clk_en && cand_valid && !candidate_direction_select_q[cand_port][cand_dir])
			|=> !copy_valid && !stat_count_pulse[sfs_pkg::EV_CAND];
	endproperty
	a_direction: assert property (p_direction) else $error("candidate from disabled direction");

	property p_marked_copy;
		@(posedge ref_clk) disable iff (rst)
		s_hit |=> s_copy_out;
	endproperty
	a_marked_copy: assert property (p_marked_copy) else $error("copy missing or unmarked");

	property p_stamp_id;
		@(posedge ref_clk) disable iff (rst)
		s_hit ##0 stamp_id_include_enable_q |=> copy_stamp[31:26] == 6'($past(cand_port));
	endproperty
	a_stamp_id: assert property (p_stamp_id) else $error("stamp identifier wrong");

	property p_sample_count;
		@(posedge ref_clk) disable iff (rst)
		s_hit |=> samples_sent_count_q[$past(cand_port)] == $past(smpl_next) && copy_stamp[7:0] == $past(smpl_next);
	endproperty
	a_sample_count: assert property (p_sample_count) else $error("sample count not advanced");

	property p_gate;
		@(posedge ref_clk) disable iff (rst)
		!sampling_global_enable_q |=> !copy_valid && !sampled_copy_marker;
	endproperty
	a_gate: assert property (p_gate) else $error("sampling while disabled");

	property p_sticky_hold;
		@(posedge ref_clk) disable iff (rst)
		(debug_event_flags_q[0] && !(wr_sticky && reg_wdata[0])) |=> debug_event_flags_q[0];
	endproperty
	a_sticky_hold: assert property (p_sticky_hold) else $error("sticky flag lost");

	property p_stat_mask;
		@(posedge ref_clk) disable iff (rst)
		(clk_en && is_cand && stat_mask_q[0]) |=> stat_count_pulse[0];
	endproperty
	a_stat_mask: assert property (p_stat_mask) else $error("masked event not counted");

endmodule : sfs_sampler

// >>> common/sfs_pkg.sv
// package: constants for the statistical frame sampler
package sfs_pkg;
	// geometry
	localparam int NUM_PORTS = 8;
	localparam int PORT_W = 3;
	localparam int ADDR_W = 8;
	localparam int RATE_W = 15;
	localparam int QUEUE_W = 3;
	localparam int SMPL_W = 8;
	localparam int FWD_W = 24;
	localparam int ID_W = 6;
	// register offsets
	localparam logic [7:0] OFF_GLOBAL = 8'h00;
	localparam logic [7:0] OFF_STICKY = 8'h04;
	localparam logic [7:0] OFF_STAT_MASK = 8'h08;
	localparam logic [7:0] OFF_IRQ_MASK = 8'h0C;
	localparam logic [1:0] PORT_REGION = 2'h1;
	// global register fields
	localparam int GBL_ENA_BIT = 0;
	localparam int GBL_ID_BIT = 1;
	localparam int GBL_QU_LSB = 4;
	// port control fields
	localparam int CTRL_RATE_LSB = 0;
	localparam int CTRL_DIR_LSB = 16;
	// stamp layout
	localparam int STAMP_ID_LSB = 26;
	localparam int STAMP_FWD_LSB = 8;
	localparam int STAMP_SMPL_LSB = 0;
	// event bits
	localparam int EV_CAND = 0;
	localparam int EV_SRC = 1;
	localparam int EV_DST = 2;
	// reset values and lfsr feedback taps
	localparam logic [31:0] RST_WORD = 32'h0000_0000;
	localparam logic [31:0] LFSR_SEED = 32'hACE1_2468;
	localparam logic [31:0] LFSR_TAPS = 32'h8020_0003;
	// frame direction
	typedef enum logic {
		SFS_DIR_RX = 1'b0,
		SFS_DIR_TX = 1'b1
	} sfs_dir_t;
endpackage : sfs_pkg

// >>> tb/sfs_pipe_model.sv
// partner: frame pipeline source and cpu queue sink
module sfs_pipe_model (
	input wire logic ref_clk,
	output logic cand_valid,
	output logic [sfs_pkg::PORT_W-1:0] cand_port,
	output logic cand_dir,
	input wire logic copy_valid
);
	timeunit 1ns;
	timeprecision 1ps;
	int copies; // copies taken by the queue
	// idle lines at time zero
	initial begin
		cand_valid = 1'b0;
		cand_port = '0;
		cand_dir = 1'b0;
		copies = 0;
	end
	// queue sink counts each copy
	always @(posedge ref_clk) begin
		if (copy_valid === 1'b1) begin
			copies <= copies + 1;
		end
	end
	// one frame a cycle, lines inverted once idle
	task automatic send(input logic [2:0] p, input logic d, input logic last);
		cand_valid <= 1'b1;
		cand_port <= p;
		cand_dir <= d;
		@(posedge ref_clk);
		if (last) begin
			cand_valid <= 1'b0;
			cand_port <= ~p;
			cand_dir <= ~d;
		end
	endtask
endmodule // sfs_pipe_model

// >>> tb/statistical_frame_sampler_tb.sv
// testbench: sampler against an integer model
module statistical_frame_sampler_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic ref_clk = 1'b0;
	logic rst = 1'b1;
	logic [7:0] reg_addr = '0;
	logic [31:0] reg_wdata = '0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic clk_en = 1'b1;
	logic [31:0] reg_rdata, copy_stamp;
	logic irq, cand_valid, cand_dir, copy_valid, copy_dir, sampled_copy_marker;
	logic [2:0] cand_port, copy_queue, copy_port, stat_count_pulse, stat_count_port;
	// model state
	int cand_c[8] = '{default: 0};
	int smpl_c[8] = '{default: 0};
	logic [1:0] dsel[8] = '{default: 2'h0};
	logic g_en = 1'b0;
	logic g_id = 1'b0;
	logic [2:0] g_qu = '0;
	logic [2:0] g_msk = '0;
	logic [2:0] stk = '0;
	logic pend = 1'b0;
	logic [2:0] pp = '0;
	logic pd = 1'b0;
	logic [31:0] rnd = 32'hF7E9;
	int fails = 0;
	int num_checks = 0;
	int cyc = 0;
	int qn = 0;
	int n0, q0;
	always #4 ref_clk = ~ref_clk;
	sfs_sampler u_dut (.ref_clk(ref_clk), .rst(rst), .clk_en(clk_en), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq),
		.cand_valid(cand_valid), .cand_port(cand_port), .cand_dir(cand_dir), .copy_valid(copy_valid),
		.copy_queue(copy_queue), .copy_port(copy_port), .copy_dir(copy_dir),
		.sampled_copy_marker(sampled_copy_marker), .copy_stamp(copy_stamp),
		.stat_count_pulse(stat_count_pulse), .stat_count_port(stat_count_port));
	sfs_pipe_model u_pipe (.ref_clk(ref_clk), .cand_valid(cand_valid), .cand_port(cand_port),
		.cand_dir(cand_dir), .copy_valid(copy_valid));
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			fails++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic results();
		$display("checks=%0d fails=%0d", num_checks, fails);
		if (fails == 0 && num_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	// model one step per enabled edge, watchdog counts every edge
	always @(posedge ref_clk) begin
		cyc++;
		// a frozen clock enable holds the model as well
		if (!rst && clk_en) begin
			chk(32'(stat_count_pulse), 32'({copy_valid & pd, copy_valid & ~pd, pend} & g_msk));
			if (pend) begin
				chk(32'(stat_count_port), 32'(pp));
			end
			if (copy_valid === 1'b1) begin
				smpl_c[pp]++;
				chk(32'(pend), 32'h1);
				chk({copy_queue, copy_port, copy_dir, sampled_copy_marker}, {g_qu, pp, pd, 1'b1});
				chk(copy_stamp, g_id ? {6'(pp), 18'(cand_c[pp]), 8'(smpl_c[pp])}
					: {24'(cand_c[pp]), 8'(smpl_c[pp])});
				stk = stk | (pd ? 3'h5 : 3'h3);
			end else if (pend) begin
				stk = stk | 3'h1;
			end
			pend = cand_valid && g_en && dsel[cand_port][cand_dir];
			pp = cand_port;
			pd = cand_dir;
			if (pend) begin
				cand_c[pp]++;
				qn++;
			end
		end
		// watchdog ends a hung run
		if (cyc == 6000) begin
			fails++;
			results();
		end
	end
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
		@(posedge ref_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		@(negedge ref_clk);
		chk(reg_rdata, exp);
	endtask
	function automatic logic [31:0] nxt(input logic [31:0] x);
		return x[0] ? (x >> 1) ^ 32'hB400_0000 : x >> 1;
	endfunction
	// back-to-back random frames, then drain
	task automatic burst(input int n);
		@(posedge ref_clk);
		for (int i = 0; i < n; i++) begin
			rnd = nxt(rnd);
			u_pipe.send(rnd[2:0], rnd[7], i == n - 1);
		end
		repeat (3) @(posedge ref_clk);
	endtask
	initial begin
		repeat (5) @(posedge ref_clk);
		rst <= 1'b0;
		rd_chk(8'h00, 32'h0);
		rd_chk(8'h44, 32'h0);
		wr(8'h30, 32'hFFFF_FFFF);
		rd_chk(8'h30, 32'h0);
		for (int p = 0; p < 8; p++) begin
			dsel[p] = 2'h3;
			wr(8'(8'h40 + 8 * p), {14'h0, 2'h3, 1'b0, 15'h7FFF});
		end
		burst(40);
		chk(32'(u_pipe.copies), 32'h0);
		rd_chk(8'h04, 32'h0);
		rd_chk(8'h4C, 32'h0);
		$display("test disabled done");
		for (int c = 0; c < 3; c++) begin
			g_en = 1'b1;
			// tx sampling keeps the identifier on
			g_id = (c != 1);
			g_qu = 3'(5 + c);
			g_msk = 3'(7 - 2 * c);
			wr(8'h08, {29'h0, g_msk});
			wr(8'h00, {25'h0, g_qu, 2'h0, g_id, g_en});
			for (int p = 0; p < 8; p++) begin
				dsel[p] = (c == 1) ? 2'h1 : ((c == 2) ? 2'(p) : 2'h3);
				wr(8'(8'h40 + 8 * p), {14'h0, dsel[p], 1'b0, (c == 0) ? 15'h0 : ((c == 1) ? 15'h4000 : 15'h7FFF)});
			end
			n0 = u_pipe.copies;
			q0 = qn;
			burst(200);
			n0 = u_pipe.copies - n0;
			q0 = qn - q0;
			chk(32'((c == 0) ? n0 == 0 : ((c == 1) ? (4 * n0 >= q0 && 4 * n0 <= 3 * q0) : n0 + 2 >= q0)),
				32'h1);
			for (int p = 0; p < 8; p++) begin
				rd_chk(8'(8'h44 + 8 * p), {24'(cand_c[p]), 8'(smpl_c[p])});
			end
			$display("test rate %0d done", c);
		end
		rd_chk(8'h04, {29'h0, stk});
		wr(8'h04, 32'h0);
		rd_chk(8'h04, {29'h0, stk});
		wr(8'h0C, 32'h2);
		@(negedge ref_clk);
		chk(32'(irq), 32'(stk[1]));
		wr(8'h04, 32'h2);
		stk[1] = 1'b0;
		@(negedge ref_clk);
		chk(32'(irq), 32'h0);
		rd_chk(8'h04, {29'h0, stk});
		$display("test sticky done");
		// frozen clock enable: writes and frames leave no trace
		n0 = u_pipe.copies;
		@(posedge ref_clk);
		clk_en <= 1'b0;
		wr(8'h48, 32'h0);
		burst(20);
		clk_en <= 1'b1;
		chk(32'(u_pipe.copies - n0), 32'h0);
		rd_chk(8'h48, {14'h0, dsel[1], 1'b0, 15'h7FFF});
		rd_chk(8'h4C, {24'(cand_c[1]), 8'(smpl_c[1])});
		$display("test freeze done");
		results();
	end
endmodule // statistical_frame_sampler_tb
